// file: core/stc_regs.vh
// Register map, field layout and timing for the scope trigger/capture core.
// Assumes 32-bit APB access, one aligned word per register.
//
// Summary of operation
// - Rising type fires on upward level crossing
// - Falling type fires on downward level crossing
// - Absolute type fires outside plus/minus level
// - Highpass type filters signal, compares plus/minus
// - Smoothing in rising, falling, absolute paths
// - Absolute/highpass types refuse negative level
// - Trigger point at 0/25/50/75 percent
// - Timebase codes span 5us to 20s
// - Trigger or timebase change clears record
// - Remote control blocks trigger/timebase writes
// - Record every channel of source group
// - Surge capture forces high current range
// - Surge capture bypasses bandwidth limit
// - Surge capture locates first trace maximum
// - Continuous mode rearms; commands stop/switch
// - Single mode stops after one capture
// - Single command aborts, continuous switches
// - Report pretrigger, waiting, posttrigger state
// - Record is 32768 samples per signal
// - Store samples without interpolation
// - Presentation settings leave record intact
// - Normal mode keeps group bandwidth limit
`ifndef STC_REGS_VH
`define STC_REGS_VH
`define STC_TRIG_CFG 8'h00
`define STC_LEVEL 8'h04
`define STC_TIMEBASE 8'h08
`define STC_DECIM 8'h0C
`define STC_CMD 8'h10
`define STC_STATUS 8'h14
`define STC_CURSOR 8'h18
`define STC_GROUP 8'h1C
`define STC_LINK 8'h20
`define STC_MEAS 8'h24
`define STC_RD_PTR 8'h28
`define STC_RD_DATA 8'h2C
`define STC_CH_MASK 8'h30
`define STC_TYPE_LSB 0
`define STC_POS_LSB 2
`define STC_SRC_LSB 4
`define STC_SURGE_BIT 8
`define STC_BW_BIT 8
`define STC_TR1_LSB 16
`define STC_RDCH_LSB 16
`define STC_TB_MAX 5'h14
`define STC_TYPE_RISE 2'h0
`define STC_TYPE_FALL 2'h1
`define STC_TYPE_ABS 2'h2
`define STC_TYPE_HP 2'h3
`define STC_LINK_RST 8'hE4
`define STC_LP_SHIFT 2
`define STC_HP_SHIFT 8
`define STC_CLK_MHZ 250
`define STC_REARM_NS 1000
`endif

// file: core/stc_core.v
// Scope trigger and capture engine behind APB registers.
// Samples come with a valid strobe, synchronous to clk_in;
// range and bandwidth outputs go to the front end.
`timescale 1ns/1ps
`include "stc_regs.vh"
module stc_core #(
    parameter NCH = 4,
    parameter CW = 2,
    parameter W = 24,
    parameter AW = 15,
    parameter DEPTH = 32768
) (
    input wire clk_in,
    input wire rst_n_in,
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [7:0] paddr_in,
    input wire [31:0] pwdata_in,
    output reg [31:0] prdata_out,
    output reg pready_out,
    output reg pslverr_out,
    input wire samp_valid_in,
    input wire [NCH*W-1:0] samp_data_in,
    input wire remote_in,
    input wire [NCH-1:0] unscaled_cur_in,
    output reg [NCH-1:0] hi_range_out,
    output reg bw_limit_out,
    output reg [1:0] capture_state_out,
    output reg busy_out
);
localparam ST_IDLE = 3'd0;
localparam ST_PRE = 3'd1;
localparam ST_WAIT = 3'd2;
localparam ST_POST = 3'd3;
localparam ST_SCAN = 3'd4;
localparam ST_REARM = 3'd5;
localparam LS = `STC_LP_SHIFT;
localparam HS = `STC_HP_SHIFT;
localparam integer REARM_CYC = (`STC_REARM_NS * `STC_CLK_MHZ + 999) / 1000;

reg [2:0] st_q;
reg continuous_capture_q, surge_q, bw_q, rec_q, rej_q, sv_q, scan_d_q;
reg [1:0] type_q, pos_q;
reg [CW-1:0] src_q, tr1_q, rdch_q;
reg signed [W-1:0] lvl_q, mx_q;
reg [4:0] tb_q;
reg [19:0] dec_q, dcnt_q;
reg [2*NCH-1:0] grp_q;
reg [7:0] link_q;
reg [NCH-1:0] rng_q, mask_q;
reg [AW-1:0] rdix_q, cur_q, wptr_q, tptr_q, start_q, sidx_q;
reg [AW:0] cnt_q, sc_q;
reg [8:0] rearm_q;
reg signed [W+LS:0] lp_y_q;
reg signed [W+HS:0] hp_y_q;
reg signed [W+1:0] prev_q;

// Bus decode
wire acc = psel_in & penable_in & pready_out;
wire wr = acc & pwrite_in;
wire [7:0] a = paddr_in;
wire is_cfg = (a[7:4] == 4'h0) & (a[1:0] == 2'h0);
wire [1:0] n_type = (a == `STC_TRIG_CFG) ? pwdata_in[`STC_TYPE_LSB+1:`STC_TYPE_LSB] : type_q;
wire signed [W-1:0] n_lvl = (a == `STC_LEVEL) ? pwdata_in[W-1:0] : lvl_q;
wire bad_lvl = n_type[1] & n_lvl[W-1];
wire bad_tb = (a == `STC_TIMEBASE) & (pwdata_in[4:0] > `STC_TB_MAX);
wire cfg_bad = remote_in | bad_lvl | bad_tb;
wire cfg_wr = wr & is_cfg;
wire cfg_ok = cfg_wr & ~cfg_bad;
wire cmd_s = wr & (a == `STC_CMD) & pwdata_in[0];
wire cmd_c = wr & (a == `STC_CMD) & pwdata_in[1];
wire mapped = (a <= `STC_CH_MASK) & (a[1:0] == 2'h0);
// Record reads stall while the maximum search owns the read port
wire rd_hold = (a == `STC_RD_DATA) & ((st_q == ST_SCAN) | scan_d_q);

// Sample path
wire se = samp_valid_in & (dcnt_q == 20'h00000);
wire signed [W-1:0] x = samp_data_in[src_q*W +: W];
wire signed [W+LS:0] x_lp = {{(LS+1){x[W-1]}}, x};
wire signed [W+HS:0] x_hp = {{(HS+1){x[W-1]}}, x};
wire signed [W+LS:0] lp_y_d = lp_y_q + x_lp - (lp_y_q >>> LS);
wire signed [W+HS:0] hp_y_d = hp_y_q + x_hp - (hp_y_q >>> HS);
wire signed [W+1:0] lp_v = {lp_y_q[W+LS], lp_y_q[W+LS:LS]};
wire signed [W+1:0] hp_v = {x[W-1], x[W-1], x} - {hp_y_q[W+HS], hp_y_q[W+HS:HS]};
wire signed [W+1:0] lv = {lvl_q[W-1], lvl_q[W-1], lvl_q};
wire signed [W+1:0] nlv = -lv;
reg trig;
always @* begin
    case (type_q)
        `STC_TYPE_RISE: trig = (prev_q <= lv) & (lp_v > lv);
        `STC_TYPE_FALL: trig = (prev_q >= lv) & (lp_v < lv);
        `STC_TYPE_ABS: trig = (lp_v > lv) | (lp_v < nlv);
        `STC_TYPE_HP: trig = (hp_v > lv) | (hp_v < nlv);
        default: trig = 1'b0;
    endcase
end

// Pre and post lengths from trigger position
wire [AW-1:0] pre_need = {pos_q, {(AW-2){1'b0}}};
wire [AW:0] pre_w = {1'b0, pre_need};
wire [AW:0] post_need = DEPTH[AW:0] - pre_w;
wire we = se & (((st_q == ST_PRE) & (cnt_q < pre_w)) | (st_q == ST_WAIT) |
    ((st_q == ST_POST) & (cnt_q < post_need)));
wire capt = (st_q == ST_PRE) | (st_q == ST_WAIT) | (st_q == ST_POST);
wire running = st_q != ST_IDLE;

// Source group plus period-linked groups
wire [1:0] sg = grp_q[src_q*2 +: 2];
reg [NCH-1:0] gmask;
integer i;
always @* begin
    gmask = {NCH{1'b0}};
    for (i = 0; i < NCH; i = i + 1) begin
        gmask[i] = (grp_q[i*2 +: 2] == sg) |
            (grp_q[i*2 +: 2] == link_q[sg*2 +: 2]) |
            (link_q[grp_q[i*2 +: 2]*2 +: 2] == sg);
    end
end

// Record memories, one per channel
wire [AW-1:0] raddr = start_q + ((st_q == ST_SCAN) ? sc_q[AW-1:0] : rdix_q);
wire [NCH*W-1:0] rq;
genvar g;
generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
        reg [W-1:0] mem [0:DEPTH-1];
        reg [W-1:0] rq_q;
        always @(posedge clk_in) begin
            if (we & mask_q[g]) begin
                mem[wptr_q] <= samp_data_in[g*W +: W];
            end
            rq_q <= mem[raddr];
        end
        assign rq[g*W +: W] = rq_q;
    end
endgenerate
wire signed [W-1:0] scan_v = rq[tr1_q*W +: W];
wire [W-1:0] rd_v = rq[rdch_q*W +: W];

// Register read mux
reg [31:0] rdat;
always @* begin
    rdat = 32'h00000000;
    case (a)
        `STC_TRIG_CFG: begin
            rdat[`STC_TYPE_LSB+1:`STC_TYPE_LSB] = type_q;
            rdat[`STC_POS_LSB+1:`STC_POS_LSB] = pos_q;
            rdat[`STC_SRC_LSB+CW-1:`STC_SRC_LSB] = src_q;
            rdat[`STC_SURGE_BIT] = surge_q;
        end
        `STC_LEVEL: rdat[W-1:0] = lvl_q;
        `STC_TIMEBASE: rdat[4:0] = tb_q;
        `STC_DECIM: rdat[19:0] = dec_q;
        `STC_STATUS: rdat[5:0] = {rej_q, rec_q, continuous_capture_q, st_q};
        `STC_CURSOR: rdat[AW-1:0] = cur_q;
        `STC_GROUP: rdat[2*NCH-1:0] = grp_q;
        `STC_LINK: rdat[7:0] = link_q;
        `STC_MEAS: begin
            rdat[NCH-1:0] = rng_q;
            rdat[`STC_BW_BIT] = bw_q;
            rdat[`STC_TR1_LSB+CW-1:`STC_TR1_LSB] = tr1_q;
        end
        `STC_RD_PTR: begin
            rdat[AW-1:0] = rdix_q;
            rdat[`STC_RDCH_LSB+CW-1:`STC_RDCH_LSB] = rdch_q;
        end
        `STC_RD_DATA: rdat[W-1:0] = rec_q ? rd_v : {W{1'b0}};
        `STC_CH_MASK: rdat[NCH-1:0] = mask_q;
        default: rdat = 32'h00000000;
    endcase
end

// APB slave: one wait state, pslverr on unmapped or refused writes
always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        pready_out <= 1'b0;
        prdata_out <= 32'h00000000;
        pslverr_out <= 1'b0;
        scan_d_q <= 1'b0;
    end else begin
        scan_d_q <= st_q == ST_SCAN;
        pready_out <= psel_in & penable_in & ~pready_out & ~rd_hold;
        prdata_out <= rdat;
        pslverr_out <= ~mapped | (pwrite_in & is_cfg & cfg_bad);
    end
end

// Configuration registers
always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        type_q <= `STC_TYPE_RISE;
        pos_q <= 2'h0;
        src_q <= {CW{1'b0}};
        surge_q <= 1'b0;
        lvl_q <= {W{1'b0}};
        tb_q <= 5'h00;
        dec_q <= 20'h00000;
        grp_q <= {2*NCH{1'b0}};
        link_q <= `STC_LINK_RST;
        rng_q <= {NCH{1'b0}};
        bw_q <= 1'b0;
        tr1_q <= {CW{1'b0}};
        rdch_q <= {CW{1'b0}};
        rdix_q <= {AW{1'b0}};
        rej_q <= 1'b0;
    end else begin
        if (cfg_wr) begin
            rej_q <= cfg_bad;
        end
        if (cfg_ok) begin
            type_q <= n_type;
            lvl_q <= n_lvl;
            if (a == `STC_TRIG_CFG) begin
                pos_q <= pwdata_in[`STC_POS_LSB+1:`STC_POS_LSB];
                src_q <= pwdata_in[`STC_SRC_LSB+CW-1:`STC_SRC_LSB];
                surge_q <= pwdata_in[`STC_SURGE_BIT];
            end
            if (a == `STC_TIMEBASE) begin
                tb_q <= pwdata_in[4:0];
            end
            if (a == `STC_DECIM) begin
                dec_q <= pwdata_in[19:0];
            end
        end
        // Presentation and group settings do not touch the record
        if (wr & (a == `STC_GROUP)) begin
            grp_q <= pwdata_in[2*NCH-1:0];
        end
        if (wr & (a == `STC_LINK)) begin
            link_q <= pwdata_in[7:0];
        end
        if (wr & (a == `STC_MEAS)) begin
            rng_q <= pwdata_in[NCH-1:0];
            bw_q <= pwdata_in[`STC_BW_BIT];
            tr1_q <= pwdata_in[`STC_TR1_LSB+CW-1:`STC_TR1_LSB];
        end
        if (wr & (a == `STC_RD_PTR)) begin
            rdix_q <= pwdata_in[AW-1:0];
            rdch_q <= pwdata_in[`STC_RDCH_LSB+CW-1:`STC_RDCH_LSB];
        end
    end
end

// Decimation and trigger filters
always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        dcnt_q <= 20'h00000;
        lp_y_q <= {(W+LS+1){1'b0}};
        hp_y_q <= {(W+HS+1){1'b0}};
        prev_q <= {(W+2){1'b0}};
    end else begin
        if (cfg_ok) begin
            dcnt_q <= 20'h00000;
        end else if (samp_valid_in) begin
            dcnt_q <= (dcnt_q >= dec_q) ? 20'h00000 : dcnt_q + 20'h00001;
        end
        if (samp_valid_in) begin
            lp_y_q <= lp_y_d;
        end
        if (se) begin
            hp_y_q <= hp_y_d;
            prev_q <= lp_v;
        end
    end
end

// Capture sequencer
always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        st_q <= ST_IDLE;
        continuous_capture_q <= 1'b0;
        rec_q <= 1'b0;
        mask_q <= {NCH{1'b0}};
        wptr_q <= {AW{1'b0}};
        cnt_q <= {(AW+1){1'b0}};
        tptr_q <= {AW{1'b0}};
        start_q <= {AW{1'b0}};
        sc_q <= {(AW+1){1'b0}};
        sidx_q <= {AW{1'b0}};
        sv_q <= 1'b0;
        mx_q <= {W{1'b0}};
        cur_q <= {AW{1'b0}};
        rearm_q <= 9'h000;
    end else begin
        if (we) begin
            wptr_q <= wptr_q + {{(AW-1){1'b0}}, 1'b1};
        end
        if (cfg_ok) begin
            rec_q <= 1'b0;
            if (running) begin
                st_q <= ST_PRE;
                cnt_q <= {(AW+1){1'b0}};
                mask_q <= gmask;
            end
        end else if (running & cmd_c & continuous_capture_q) begin
            st_q <= ST_IDLE;
        end else if (running & cmd_s & continuous_capture_q) begin
            continuous_capture_q <= 1'b0;
        end else if (running & cmd_s) begin
            st_q <= ST_IDLE;
        end else if (running & cmd_c) begin
            continuous_capture_q <= 1'b1;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    if (cmd_s | cmd_c) begin
                        continuous_capture_q <= cmd_c & ~cmd_s;
                        st_q <= ST_PRE;
                        cnt_q <= {(AW+1){1'b0}};
                        mask_q <= gmask;
                        rec_q <= 1'b0;
                    end
                end
                ST_PRE: begin
                    if (cnt_q >= pre_w) begin
                        st_q <= ST_WAIT;
                    end else if (se) begin
                        cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
                    end
                end
                ST_WAIT: begin
                    if (se & trig) begin
                        tptr_q <= wptr_q;
                        cnt_q <= {{AW{1'b0}}, 1'b1};
                        st_q <= ST_POST;
                    end
                end
                ST_POST: begin
                    if (cnt_q >= post_need) begin
                        start_q <= tptr_q - pre_need;
                        rec_q <= 1'b1;
                        sc_q <= {(AW+1){1'b0}};
                        sv_q <= 1'b0;
                        rearm_q <= 9'h000;
                        if (surge_q) begin
                            st_q <= ST_SCAN;
                        end else if (continuous_capture_q) begin
                            st_q <= ST_REARM;
                        end else begin
                            st_q <= ST_IDLE;
                        end
                    end else if (se) begin
                        cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
                    end
                end
                ST_SCAN: begin
                    sv_q <= ~sc_q[AW];
                    sidx_q <= sc_q[AW-1:0];
                    if (~sc_q[AW]) begin
                        sc_q <= sc_q + {{AW{1'b0}}, 1'b1};
                    end
                    if (sv_q & ((sidx_q == {AW{1'b0}}) | (scan_v > mx_q))) begin
                        mx_q <= scan_v;
                        cur_q <= sidx_q;
                    end
                    if (sc_q[AW] & ~sv_q) begin
                        st_q <= continuous_capture_q ? ST_REARM : ST_IDLE;
                    end
                end
                ST_REARM: begin
                    if (rearm_q >= REARM_CYC[8:0] - 9'h001) begin
                        st_q <= ST_PRE;
                        cnt_q <= {(AW+1){1'b0}};
                        mask_q <= gmask;
                        rec_q <= 1'b0;
                    end else begin
                        rearm_q <= rearm_q + 9'h001;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end
end

// Front-end overrides, state report
always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        hi_range_out <= {NCH{1'b0}};
        bw_limit_out <= 1'b0;
        capture_state_out <= 2'h3;
        busy_out <= 1'b0;
    end else begin
        hi_range_out <= rng_q | ({NCH{surge_q & capt}} & unscaled_cur_in);
        bw_limit_out <= bw_q & ~(surge_q & capt);
        busy_out <= running;
        case (st_q)
            ST_PRE: capture_state_out <= 2'h0;
            ST_WAIT: capture_state_out <= 2'h1;
            ST_POST: capture_state_out <= 2'h2;
            default: capture_state_out <= 2'h3;
        endcase
    end
end
endmodule // stc_core

// file: testbench/stc_core_asserts.sv
// Port checker for the trigger/capture core.
// Assumes the APB master holds each request until pready.
`timescale 1ns/1ps
module stc_core_asserts #(parameter NCH = 4) (
    input wire clk_in,
    input wire rst_n_in,
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [7:0] paddr_in,
    input wire [31:0] pwdata_in,
    input wire pready_out,
    input wire pslverr_out,
    input wire remote_in,
    input wire [NCH-1:0] unscaled_cur_in,
    input wire [NCH-1:0] hi_range_out,
    input wire bw_limit_out,
    input wire [1:0] capture_state_out,
    input wire busy_out
);
    wire commit = psel_in && penable_in && pready_out && pwrite_in;
    reg surge_q;
    reg [4:0] meas_q;
    // Shadow of accepted writes
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            surge_q <= 1'b0;
            meas_q <= 5'h00;
        end else if (commit && !pslverr_out) begin
            if (paddr_in == 8'h00)
                surge_q <= pwdata_in[8];
            if (paddr_in == 8'h24)
                meas_q <= {pwdata_in[8], pwdata_in[3:0]};
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    AST_PREADY_PULSE: assert property (pready_out |=> !pready_out) else $error("pready too long");
    AST_PREADY_TIME: assert property (psel_in && !penable_in && paddr_in != 8'h2C |-> ##2 pready_out)
        else $error("pready late");
    AST_REMOTE_REFUSE: assert property (
        commit && remote_in && paddr_in <= 8'h0C && paddr_in[1:0] == 2'h0 |-> pslverr_out)
        else $error("remote write taken");
    AST_TB_RANGE: assert property (
        commit && paddr_in == 8'h08 && pwdata_in[4:0] > 5'h14 |-> pslverr_out)
        else $error("timebase range");
    AST_SURGE_OVR: assert property (
        surge_q && capture_state_out != 2'h3 && $past(capture_state_out) != 2'h3
        |-> !bw_limit_out && hi_range_out == (meas_q[3:0] | unscaled_cur_in))
        else $error("surge override missing");
    AST_RESTORE: assert property (
        capture_state_out == 2'h3 && $past(capture_state_out) == 2'h3 && !$past(commit)
        |-> bw_limit_out == meas_q[4] && hi_range_out == meas_q[3:0])
        else $error("settings not restored");
    AST_BUSY: assert property (capture_state_out != 2'h3 |-> busy_out) else $error("not busy");
    AST_POST_END: assert property (
        $past(capture_state_out) == 2'h2 && capture_state_out != 2'h2 |-> capture_state_out == 2'h3)
        else $error("post exit state");
    AST_PRE_NEXT: assert property ($past(capture_state_out) == 2'h0 |-> capture_state_out != 2'h2)
        else $error("early trigger");
endmodule // stc_core_asserts

bind stc_core stc_core_asserts #(.NCH(NCH)) stc_core_asserts_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .pready_out(pready_out), .pslverr_out(pslverr_out), .remote_in(remote_in),
    .unscaled_cur_in(unscaled_cur_in), .hi_range_out(hi_range_out), .bw_limit_out(bw_limit_out),
    .capture_state_out(capture_state_out), .busy_out(busy_out));

// file: testbench/stc_src.sv
// Sample source standing in for the measurement front end.
// Channel g carries value plus g; slow halves the rate.
`timescale 1ns/1ps
module stc_src #(parameter NCH = 4, parameter W = 24) (
    input wire clk_in,
    input wire rst_n_in,
    input wire slow_in,
    input wire [W-1:0] value_in,
    output reg samp_valid_out,
    output reg [NCH*W-1:0] samp_data_out
);
    integer g;
    wire nxt = slow_in ? !samp_valid_out : 1'b1;
    // Inverted data between strobes
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            samp_valid_out <= 1'b0;
            samp_data_out <= {NCH*W{1'b0}};
        end else begin
            samp_valid_out <= nxt;
            for (g = 0; g < NCH; g = g + 1)
                samp_data_out[g*W +: W] <= nxt ? value_in + g : ~(value_in + g);
        end
    end
endmodule // stc_src

// file: testbench/test_scope_trigger_capture.sv
// Bench for the trigger/capture core: APB master, sample source, scenarios.
// Depth 1024 keeps each capture short.
`timescale 1ns/1ps
`include "stc_regs.vh"
module test_scope_trigger_capture;
    localparam NCH = 4;
    localparam W = 24;
    localparam DEPTH = 1024;
    reg clk_in = 1'b0;
    reg rst_n_in = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h0;
    reg remote = 1'b0;
    reg slow = 1'b0;
    reg [NCH-1:0] unscaled = 4'h3;
    reg [W-1:0] value = 24'h0;
    wire [31:0] prdata;
    wire pready, pslverr, svalid, bw, busy;
    wire [NCH*W-1:0] sdata;
    wire [NCH-1:0] hi;
    wire [1:0] st;
    integer fail_count = 0;
    integer checks_done = 0;
    reg [31:0] rd;
    reg err;

    initial begin
        forever #2 clk_in = ~clk_in;
    end

    stc_src #(.NCH(NCH), .W(W)) stc_src_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .slow_in(slow),
        .value_in(value), .samp_valid_out(svalid), .samp_data_out(sdata));
    stc_core #(.AW(10), .DEPTH(DEPTH)) stc_core_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .samp_valid_in(svalid), .samp_data_in(sdata),
        .remote_in(remote), .unscaled_cur_in(unscaled), .hi_range_out(hi), .bw_limit_out(bw),
        .capture_state_out(st), .busy_out(busy));

    task ok;
        checks_done = checks_done + 1;
    endtask
    task bad(input string msg);
        begin
            checks_done = checks_done + 1;
            fail_count = fail_count + 1;
            $display("[FAIL] %0t %0s", $time, msg);
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d mismatches %0d", checks_done, fail_count);
            if (fail_count == 0 && checks_done > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    // State wait, or busy wait when b set
    task wait_for(input b, input [1:0] s, input integer lim);
        integer n;
        begin
            n = 0;
            while ((b ? {1'b0, busy} : st) !== s) begin
                @(posedge clk_in);
                n = n + 1;
                if (n > lim) begin
                    bad("wait timed out");
                    finish_test;
                end
            end
        end
    endtask
    task apb(input w, input [7:0] a, input [31:0] d);
        integer n;
        begin
            @(posedge clk_in);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clk_in);
            penable <= 1'b1;
            n = 0;
            @(posedge clk_in);
            while (pready !== 1'b1) begin
                @(posedge clk_in);
                n = n + 1;
                if (n > 40000) begin
                    bad("apb timed out");
                    finish_test;
                end
            end
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rdr(input [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask

    task t_reset;
        begin
            if (st === 2'h3 && busy === 1'b0 && bw === 1'b0 && hi === 4'h0) ok(); else bad("reset outputs");
            rdr(`STC_LINK);
            if (rd === 32'h000000E4) ok(); else bad("link reset value");
            rdr(8'h34);
            if (err === 1'b1 && rd === 32'h0) ok(); else bad("unmapped read");
        end
    endtask
    task t_refuse;
        begin
            wr(`STC_TIMEBASE, 32'h3);
            remote <= 1'b1;
            wr(`STC_TIMEBASE, 32'h5);
            if (err === 1'b1) ok(); else bad("remote write taken");
            rdr(`STC_TIMEBASE);
            if (err === 1'b0 && rd[4:0] === 5'h03) ok(); else bad("remote read");
            remote <= 1'b0;
            rdr(`STC_STATUS);
            if (rd[5] === 1'b1) ok(); else bad("refusal flag");
            wr(`STC_TIMEBASE, 32'h15);
            if (err === 1'b1) ok(); else bad("timebase 21 taken");
            wr(`STC_TIMEBASE, 32'h14);
            rdr(`STC_TIMEBASE);
            if (err === 1'b0 && rd[4:0] === 5'h14) ok(); else bad("timebase 20");
            wr(`STC_TRIG_CFG, {30'h0, `STC_TYPE_ABS});
            wr(`STC_LEVEL, 32'h00FFFFFB);
            if (err === 1'b1) ok(); else bad("negative level taken");
        end
    endtask
    task t_type(input [1:0] typ, input [1:0] pos, input [23:0] lvl, input [23:0] v0, input [23:0] v1);
        integer n, t;
        begin
            value <= v0;
            wr(`STC_LEVEL, {8'h00, lvl});
            wr(`STC_TRIG_CFG, {28'h0, pos, typ});
            wr(`STC_CMD, 32'h1);
            n = 0;
            t = 0;
            while (st !== 2'h1 && t < 4 * DEPTH) begin
                @(posedge clk_in);
                t = t + 1;
                if (st === 2'h0)
                    n = n + 1;
            end
            if (n >= pos * DEPTH / 4 && n <= pos * DEPTH / 4 + 3) ok(); else bad("pretrigger length");
            // Glitch smoothed except on highpass path
            if (typ != `STC_TYPE_HP) begin
                value <= v1;
                @(posedge clk_in);
                value <= v0;
            end
            repeat (40) @(posedge clk_in);
            if (st === 2'h1) ok(); else bad("early trigger");
            value <= v1;
            wait_for(1'b0, 2'h2, 40);
            wait_for(1'b0, 2'h3, 2 * DEPTH);
            repeat (2) @(posedge clk_in);
            if (busy === 1'b0) ok(); else bad("single running");
        end
    endtask
    task t_record;
        begin
            rdr(`STC_CH_MASK);
            if (rd[3:0] === 4'h3) ok(); else bad("channel mask");
            wr(`STC_RD_PTR, DEPTH - 1);
            rdr(`STC_RD_DATA);
            if (rd[23:0] === 24'hFFF448) ok(); else bad("last sample");
            wr(`STC_RD_PTR, 32'h00010000);
            rdr(`STC_RD_DATA);
            if (rd[23:0] === 24'h000BB9) ok(); else bad("channel 1 sample");
            wr(`STC_MEAS, 32'h00000100);
            rdr(`STC_STATUS);
            if (rd[4] === 1'b1) ok(); else bad("record lost");
            wr(`STC_TIMEBASE, 32'h14);
            rdr(`STC_STATUS);
            if (rd[4] === 1'b0) ok(); else bad("record kept");
        end
    endtask
    task t_surge;
        begin
            if (bw === 1'b1 && hi === 4'h0) ok(); else bad("normal bandwidth");
            value <= 24'h0;
            wr(`STC_LEVEL, 32'd2000);
            wr(`STC_TRIG_CFG, 32'h00000102);
            wr(`STC_CMD, 32'h1);
            wait_for(1'b0, 2'h1, 20);
            repeat (2) @(posedge clk_in);
            if (bw === 1'b0 && hi === 4'h3) ok(); else bad("surge override");
            value <= -24'd3000;
            wait_for(1'b0, 2'h2, 40);
            repeat (200) @(posedge clk_in);
            value <= 24'd5000;
            @(posedge clk_in);
            value <= -24'd3000;
            wait_for(1'b1, 2'h0, 4 * DEPTH);
            rdr(`STC_CURSOR);
            if (rd[14:0] >= 15'd190 && rd[14:0] <= 15'd212) ok(); else bad("cursor");
            if (bw === 1'b1 && hi === 4'h0) ok(); else bad("not restored");
        end
    endtask
    task t_modes;
        begin
            slow <= 1'b1;
            wr(`STC_TRIG_CFG, {30'h0, `STC_TYPE_ABS});
            wr(`STC_CMD, 32'h2);
            wait_for(1'b0, 2'h2, 80);
            wait_for(1'b0, 2'h3, 4 * DEPTH);
            wait_for(1'b0, 2'h2, 500);
            wr(`STC_CMD, 32'h1);
            rdr(`STC_STATUS);
            if (rd[3] === 1'b0 && busy === 1'b1) ok(); else bad("to single");
            wr(`STC_CMD, 32'h2);
            rdr(`STC_STATUS);
            if (rd[3] === 1'b1 && busy === 1'b1) ok(); else bad("to continuous");
            wr(`STC_CMD, 32'h2);
            repeat (2) @(posedge clk_in);
            if (busy === 1'b0) ok(); else bad("not stopped");
            value <= 24'h0;
            repeat (100) @(posedge clk_in);
            wr(`STC_CMD, 32'h1);
            wait_for(1'b0, 2'h1, 40);
            wr(`STC_CMD, 32'h1);
            repeat (2) @(posedge clk_in);
            if (busy === 1'b0 && st === 2'h3) ok(); else bad("single not aborted");
        end
    endtask

    initial begin
        repeat (6) @(posedge clk_in);
        rst_n_in <= 1'b1;
        t_reset;
        wr(`STC_DECIM, 32'h0);
        wr(`STC_GROUP, 32'h00000050);
        t_refuse;
        t_type(`STC_TYPE_HP, 2'h0, 24'd500, 24'd0, 24'd1000);
        t_type(`STC_TYPE_ABS, 2'h1, 24'd2000, 24'd1000, -24'd3000);
        t_type(`STC_TYPE_RISE, 2'h2, 24'd100, -24'd3000, 24'd1000);
        t_type(`STC_TYPE_FALL, 2'h3, 24'd100, 24'd3000, -24'd3000);
        t_record;
        t_surge;
        t_modes;
        finish_test;
    end
endmodule // test_scope_trigger_capture
